// ==== rtl/mad_pkg.sv ====
// constants and types for the memory attribute decoder
package mad_pkg;

  typedef enum logic [1:0] {
    MAD_STRONG = 2'h0,
    MAD_DEVICE = 2'h1,
    MAD_NORMAL = 2'h2
  } mad_mem_type_t;

  typedef struct packed {
    mad_mem_type_t mem_type;
    logic [1:0]    inner;
    logic [1:0]    outer;
    logic          shareable;
  } mad_attr_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        fetch;
    logic        priv;
    logic        region_hit;
    logic [4:0]  region_code;
    logic        region_shareable;
    logic        region_noexec;
  } mad_req_t;

  // cacheability codes
  localparam logic [1:0] MAD_NONCACHE = 2'h0;
  localparam logic [1:0] MAD_WBA      = 2'h1;
  localparam logic [1:0] MAD_WTH      = 2'h2;

  // address fields
  localparam int MAD_GRP_HI = 31;
  localparam int MAD_GRP_LO = 29;
  localparam int MAD_SYS_HI = 28;
  localparam int MAD_SYS_LO = 20;

  // default map groups
  localparam logic [2:0] MAD_GRP_CODE   = 3'h0;
  localparam logic [2:0] MAD_GRP_SRAM   = 3'h1;
  localparam logic [2:0] MAD_GRP_PERIPH = 3'h2;
  localparam logic [2:0] MAD_GRP_RAM_WB = 3'h3;
  localparam logic [2:0] MAD_GRP_RAM_WTH = 3'h4;
  localparam logic [2:0] MAD_GRP_SHDEV  = 3'h5;
  localparam logic [2:0] MAD_GRP_DEV    = 3'h6;
  localparam logic [2:0] MAD_GRP_SYSTEM = 3'h7;
  localparam logic [8:0] MAD_PRIV_PERIPH_SEL = 9'h000;

  // region codes
  localparam logic [4:0] MAD_RC_STRONG  = 5'h00;
  localparam logic [4:0] MAD_RC_SHDEV   = 5'h01;
  localparam logic [4:0] MAD_RC_NORM_A  = 5'h02;
  localparam logic [4:0] MAD_RC_NORM_B  = 5'h03;
  localparam logic [4:0] MAD_RC_NORM_C  = 5'h04;
  localparam logic [4:0] MAD_RC_IMPDEF  = 5'h06;
  localparam logic [4:0] MAD_RC_WBA     = 5'h07;
  localparam logic [4:0] MAD_RC_DEV     = 5'h08;

  // register offsets
  localparam logic [11:0] MAD_CTRL_OFF  = 12'h000;
  localparam logic [11:0] MAD_STAT_OFF  = 12'h004;
  localparam logic [11:0] MAD_FADDR_OFF = 12'h008;
  localparam logic [11:0] MAD_FCNT_OFF  = 12'h00c;

  // control fields
  localparam int MAD_CTRL_ENABLE  = 0;
  localparam int MAD_CTRL_PRIVDEF = 1;
  localparam int MAD_CTRL_FLT_EN  = 2;
  localparam int MAD_CTRL_DEM_LO  = 4;
  localparam int MAD_CTRL_DEM_HI  = 5;
  localparam logic [31:0] MAD_CTRL_RESET = 32'h0000_0000;

  // status fields
  localparam int MAD_STAT_MM   = 8;
  localparam int MAD_STAT_HARD = 9;
  localparam int MAD_STAT_DEF  = 10;

  // demotion modes
  localparam logic [1:0] MAD_DEM_NONE = 2'h0;
  localparam logic [1:0] MAD_DEM_WTH  = 2'h1;

endpackage : mad_pkg

// ==== rtl/mad_memory_attribute_decode.sv ====
// memory attribute decoder with apb control registers
//
// Behaviour
// - enabled region codes 0, 1, 8 give strong, shared device, plain device
// - codes 2-4 and 1xxxx give normal memory, cacheability from code bits
// - code 00110 gives chosen attributes; other codes are reserved
// - code 00111 gives normal write-back allocate at both levels
// - disabled, absent or overridden protection uses default map on bits 31:29
// - groups 000 and 100 are normal write-through, not shared
// - groups 001 and 011 are normal write-back allocate, not shared
// - groups 010 and 110 are device, non-cacheable, not shared
// - group 101 is device, non-cacheable, shared
// - group 111 first megabyte strong shared, else device not shared
// - default map outer cacheability equals inner cacheability
// - fetch from execute-never area raises memory-management fault
// - protection unit cannot make system region executable
// - violations report memory-management fault, else escalated hard fault
// - cache policy may be demoted, never promoted
// - strongly-ordered result is always shareable
// - system region splits into private peripheral and vendor areas
// - default map is sole map when unit absent or disabled
// - privileged miss with default-map enable falls back to default map
// - top eighth of address space decodes with system attributes unless a region hits
`timescale 1ns/10ps
module mad_memory_attribute_decode #(
  parameter int HAS_PROT = 1
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  mad_pkg::mad_req_t      req,
  output mad_pkg::mad_attr_t     attr,
  output logic                   attr_valid,
  output logic                   execute_never,
  output logic                   memory_management_fault,
  output logic                   escalated_hard_fault
);
  import mad_pkg::*;

  generate
    if (HAS_PROT != 0 && HAS_PROT != 1)
    begin : g_check
      $error("HAS_PROT must be 0 or 1");
    end
  endgenerate

  function automatic mad_attr_t mk(mad_mem_type_t t, logic [1:0] i,
                                   logic [1:0] o, logic s);
    mad_attr_t a;
    a.mem_type  = t;
    a.inner     = i;
    a.outer     = o;
    a.shareable = s;
    return a;
  endfunction : mk

  // region code decode
  function automatic mad_attr_t region_attribute_decode(logic [4:0] code,
                                                        logic s);
    mad_attr_t a;
    a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0);
    if (code[4])
      a = mk(MAD_NORMAL, code[1:0], code[3:2], s);
    else
    begin
      unique case (code)
        MAD_RC_STRONG: a = mk(MAD_STRONG, MAD_NONCACHE, MAD_NONCACHE, 1'b1);
        MAD_RC_SHDEV:  a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b1);
        MAD_RC_DEV:    a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0);
        MAD_RC_NORM_A,
        MAD_RC_NORM_B,
        MAD_RC_NORM_C: a = mk(MAD_NORMAL, code[1:0], code[1:0], s);
        MAD_RC_IMPDEF: a = mk(MAD_NORMAL, MAD_NONCACHE, MAD_NONCACHE, s);
        MAD_RC_WBA:    a = mk(MAD_NORMAL, MAD_WBA, MAD_WBA, s);
        default:       a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0);
      endcase
    end
    return a;
  endfunction : region_attribute_decode

  // fixed address map decode
  function automatic mad_attr_t default_attribute_decode(logic [31:0] pa);
    mad_attr_t  a;
    logic [1:0] c;
    a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0);
    unique case (pa[MAD_GRP_HI:MAD_GRP_LO])
      MAD_GRP_CODE,
      MAD_GRP_RAM_WTH: a = mk(MAD_NORMAL, MAD_WTH, MAD_WTH, 1'b0);
      MAD_GRP_SRAM,
      MAD_GRP_RAM_WB: a = mk(MAD_NORMAL, MAD_WBA, MAD_WBA, 1'b0);
      MAD_GRP_PERIPH,
      MAD_GRP_DEV:    a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0);
      MAD_GRP_SHDEV:  a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b1);
      MAD_GRP_SYSTEM:
      begin
        // private peripheral region, then vendor system region
        if (pa[MAD_SYS_HI:MAD_SYS_LO] == MAD_PRIV_PERIPH_SEL)
          a = mk(MAD_STRONG, MAD_NONCACHE, MAD_NONCACHE, 1'b1);
        else
          a = mk(MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0);
      end
    endcase
    c = a.inner;
    a.outer = c;
    return a;
  endfunction : default_attribute_decode

  // cache policy demotion, never promotion
  function automatic logic [1:0] demote(logic [1:0] c, logic [1:0] mode);
    logic [1:0] r;
    r = c;
    if (mode == MAD_DEM_WTH)
    begin
      if (c == MAD_WBA)
        r = MAD_WTH;
    end
    else if (mode != MAD_DEM_NONE)
      r = MAD_NONCACHE;
    return r;
  endfunction : demote

  function automatic logic addr_noexec(logic [31:0] pa);
    logic [2:0] g;
    g = pa[MAD_GRP_HI:MAD_GRP_LO];
    return (g == MAD_GRP_PERIPH) || (g >= MAD_GRP_SHDEV);
  endfunction : addr_noexec

  logic [31:0] ctrl_reg;
  logic [31:0] faddr_reg;
  logic [31:0] fcnt_reg;
  logic        mm_flag_reg;
  logic        hard_flag_reg;
  logic        def_flag_reg;
  logic        prot_on;
  logic        use_region;
  logic        miss_fault;
  logic        noexec_now;
  logic        fault_now;
  logic [1:0]  dem_mode;
  mad_attr_t   raw_attr;
  mad_attr_t   attr_next;
  logic        apb_wr;
  logic        apb_setup;
  logic        clr_mm;
  logic        clr_hard;
  logic        is_sys;

  assign dem_mode = ctrl_reg[MAD_CTRL_DEM_HI:MAD_CTRL_DEM_LO];
  assign prot_on  = (HAS_PROT == 1) && ctrl_reg[MAD_CTRL_ENABLE];
  assign use_region = prot_on && req.region_hit;
  assign miss_fault = prot_on && !req.region_hit &&
                      !(req.priv && ctrl_reg[MAD_CTRL_PRIVDEF]);
  assign is_sys = req.addr[MAD_GRP_HI:MAD_GRP_LO] == MAD_GRP_SYSTEM;

  // combinational decode path
  always_comb
  begin
    if (use_region)
      raw_attr = region_attribute_decode(req.region_code,
                                         req.region_shareable);
    else
      raw_attr = default_attribute_decode(req.addr);
    attr_next = raw_attr;
    if (raw_attr.mem_type == MAD_NORMAL)
    begin
      attr_next.inner = demote(raw_attr.inner, dem_mode);
      attr_next.outer = demote(raw_attr.outer, dem_mode);
    end
    if (raw_attr.mem_type == MAD_STRONG)
      attr_next.shareable = 1'b1;
    if (use_region)
      noexec_now = req.region_noexec || is_sys;
    else
      noexec_now = addr_noexec(req.addr);
    fault_now = req.valid && (miss_fault || (req.fetch && noexec_now));
  end

  // registered attribute outputs
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      attr          <= '{MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0};
      attr_valid    <= 1'b0;
      execute_never <= 1'b0;
    end
    else
    begin
      attr_valid <= req.valid;
      if (req.valid)
      begin
        attr          <= attr_next;
        execute_never <= noexec_now;
      end
    end
  end

  // fault pulses
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      memory_management_fault <= 1'b0;
      escalated_hard_fault    <= 1'b0;
    end
    else
    begin
      memory_management_fault <= fault_now && ctrl_reg[MAD_CTRL_FLT_EN];
      escalated_hard_fault    <= fault_now && !ctrl_reg[MAD_CTRL_FLT_EN];
    end
  end

  // apb handshake
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign clr_mm    = apb_wr && (paddr == MAD_STAT_OFF) && pwdata[MAD_STAT_MM];
  assign clr_hard  = apb_wr && (paddr == MAD_STAT_OFF) &&
                     pwdata[MAD_STAT_HARD];

  function automatic logic mapped(logic [11:0] a);
    return (a == MAD_CTRL_OFF) || (a == MAD_STAT_OFF) ||
           (a == MAD_FADDR_OFF) || (a == MAD_FCNT_OFF);
  endfunction : mapped

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !mapped(paddr);
      prdata  <= '0;
      if (apb_setup && !pwrite)
      begin
        unique case (paddr)
          MAD_CTRL_OFF:  prdata <= ctrl_reg;
          MAD_STAT_OFF:  prdata <= {21'h000000, def_flag_reg, hard_flag_reg,
                                    mm_flag_reg, 1'b0, attr};
          MAD_FADDR_OFF: prdata <= faddr_reg;
          MAD_FCNT_OFF:  prdata <= fcnt_reg;
          default:       prdata <= '0;
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ctrl_reg <= MAD_CTRL_RESET;
    else if (apb_wr && paddr == MAD_CTRL_OFF)
      ctrl_reg <= {26'h0000000, pwdata[MAD_CTRL_DEM_HI:MAD_CTRL_DEM_LO],
                   1'b0, pwdata[MAD_CTRL_FLT_EN:MAD_CTRL_ENABLE]};
  end

  // sticky fault flags, set wins over clear; default-map flag follows each valid request
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mm_flag_reg   <= 1'b0;
      hard_flag_reg <= 1'b0;
      def_flag_reg  <= 1'b0;
    end
    else
    begin
      if (fault_now && ctrl_reg[MAD_CTRL_FLT_EN])
        mm_flag_reg <= 1'b1;
      else if (clr_mm)
        mm_flag_reg <= 1'b0;
      if (fault_now && !ctrl_reg[MAD_CTRL_FLT_EN])
        hard_flag_reg <= 1'b1;
      else if (clr_hard)
        hard_flag_reg <= 1'b0;
      if (req.valid)
        def_flag_reg <= !use_region;
    end
  end

  // fault address and count
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      faddr_reg <= '0;
      fcnt_reg  <= '0;
    end
    else
    begin
      if (fault_now)
        faddr_reg <= req.addr;
      if (fault_now)
        fcnt_reg <= fcnt_reg + 32'h0000_0001;
      else if (apb_wr && paddr == MAD_FCNT_OFF)
        fcnt_reg <= '0;
    end
  end

  strong_region_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && use_region && req.region_code == MAD_RC_STRONG) |=>
    (attr.mem_type == MAD_STRONG && attr.inner == MAD_NONCACHE &&
     attr.shareable))
    else $error("strong region code misdecoded");

  wba_region_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && use_region && req.region_code == MAD_RC_WBA &&
     dem_mode == MAD_DEM_NONE) |=>
    (attr.mem_type == MAD_NORMAL && attr.inner == MAD_WBA &&
     attr.outer == MAD_WBA && attr.shareable == $past(req.region_shareable)))
    else $error("write-back region code misdecoded");

  outer_code_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && use_region && req.region_code[4] &&
     dem_mode == MAD_DEM_NONE) |=>
    (attr.outer == $past(req.region_code[3:2]) &&
     attr.inner == $past(req.region_code[1:0])))
    else $error("normal region cacheability wrong");

  default_wth_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && !use_region && dem_mode == MAD_DEM_NONE &&
     (req.addr[MAD_GRP_HI:MAD_GRP_LO] == MAD_GRP_CODE ||
      req.addr[MAD_GRP_HI:MAD_GRP_LO] == MAD_GRP_RAM_WTH)) |=>
    (attr == mk(MAD_NORMAL, MAD_WTH, MAD_WTH, 1'b0)))
    else $error("write-through group misdecoded");

  shared_dev_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && !use_region &&
     req.addr[MAD_GRP_HI:MAD_GRP_LO] == MAD_GRP_SHDEV) |=>
    (attr.mem_type == MAD_DEVICE && attr.shareable))
    else $error("shared device group misdecoded");

  sys_split_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && !use_region && is_sys) |=>
    ((attr.mem_type == MAD_STRONG) ==
     ($past(req.addr[MAD_SYS_HI:MAD_SYS_LO]) == MAD_PRIV_PERIPH_SEL)))
    else $error("system region split wrong");

  outer_inner_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && !use_region) |=> (attr.outer == attr.inner))
    else $error("default outer differs from inner");

  noexec_fetch_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && req.fetch && !use_region && addr_noexec(req.addr)) |=>
    (memory_management_fault || escalated_hard_fault))
    else $error("execute-never fetch not faulted");

  sys_noexec_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && is_sys) |=> execute_never)
    else $error("system region made executable");

  escalate_a: assert property (@(posedge ref_clk) disable iff (reset)
    escalated_hard_fault |-> !memory_management_fault &&
    !$past(ctrl_reg[MAD_CTRL_FLT_EN]))
    else $error("fault escalated while enabled");

  no_promote_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && raw_attr.inner == MAD_NONCACHE) |=>
    (attr.inner == MAD_NONCACHE))
    else $error("cache policy promoted");

  strong_share_a: assert property (@(posedge ref_clk) disable iff (reset)
    attr.mem_type == MAD_STRONG |-> attr.shareable)
    else $error("strongly-ordered not shareable");

  privdef_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req.valid && prot_on && !req.region_hit && req.priv &&
     ctrl_reg[MAD_CTRL_PRIVDEF] && !req.fetch) |=>
    (!memory_management_fault && !escalated_hard_fault))
    else $error("privileged background access faulted");

endmodule : mad_memory_attribute_decode

// ==== verif/mad_core_model.sv ====
// core-side request driver for the memory attribute decoder
`timescale 1ns/10ps
module mad_core_model (
  input  wire logic         ref_clk,
  output mad_pkg::mad_req_t req
);
  import mad_pkg::*;

  initial req = '0;

  // one aligned word per request, never across a partition edge
  task automatic send(input mad_req_t r);
    mad_req_t idle;
    idle       = ~r;
    idle.valid = 1'b0;
    @(posedge ref_clk);
    req <= r;
    @(posedge ref_clk);
    req <= idle;
    #1;
  endtask : send
endmodule : mad_core_model

// ==== verif/test_memory_attribute_decode.sv ====
// self-checking bench for the memory attribute decoder
`timescale 1ns/10ps
module test_memory_attribute_decode;
  import mad_pkg::*;

  logic        ref_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] ctrl;
  logic [31:0] a;
  mad_req_t    req;
  mad_attr_t   attr;
  logic        attr_valid;
  logic        execute_never;
  logic        memory_management_fault;
  logic        escalated_hard_fault;
  int          fail_count;
  int          compares;
  int          seed;
  int          nflt;
  logic [31:0] corner [6];

  mad_memory_attribute_decode #(.HAS_PROT(1)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .req(req), .attr(attr),
    .attr_valid(attr_valid), .execute_never(execute_never),
    .memory_management_fault(memory_management_fault),
    .escalated_hard_fault(escalated_hard_fault)
  );

  mad_core_model i_core (.ref_clk(ref_clk), .req(req));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk_attr(input mad_attr_t g, input mad_attr_t e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: attr %h want %h", $time, g, e);
    end
  endtask : chk_attr

  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: flag %b want %b", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: word %h want %h", $time, g, e);
    end
  endtask : chk_word

  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic mad_attr_t exp_def(input logic [31:0] ad);
    mad_attr_t dev;
    dev = '{MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b0};
    case (ad[31:29])
      3'h0, 3'h4: return '{MAD_NORMAL, MAD_WTH, MAD_WTH, 1'b0};
      3'h1, 3'h3: return '{MAD_NORMAL, MAD_WBA, MAD_WBA, 1'b0};
      3'h5: return '{MAD_DEVICE, MAD_NONCACHE, MAD_NONCACHE, 1'b1};
      3'h7: return (ad[28:20] == 9'h000) ?
        '{MAD_STRONG, MAD_NONCACHE, MAD_NONCACHE, 1'b1} : dev;
      default: return dev;
    endcase
  endfunction : exp_def

  function automatic mad_attr_t exp_reg(input logic [4:0] c, input logic s);
    casez (c)
      5'b00000: return '{MAD_STRONG, 2'h0, 2'h0, 1'b1};
      5'b00001: return '{MAD_DEVICE, 2'h0, 2'h0, 1'b1};
      5'b01000: return '{MAD_DEVICE, 2'h0, 2'h0, 1'b0};
      5'b0001?, 5'b00100: return '{MAD_NORMAL, c[1:0], c[1:0], s};
      5'b00110: return '{MAD_NORMAL, 2'h0, 2'h0, s};
      5'b00111: return '{MAD_NORMAL, MAD_WBA, MAD_WBA, s};
      5'b1????: return '{MAD_NORMAL, c[1:0], c[3:2], s};
      default: return '{MAD_DEVICE, 2'h0, 2'h0, 1'b0};
    endcase
  endfunction : exp_reg

  function automatic mad_attr_t dem(input mad_attr_t e, input logic [1:0] m);
    if (e.mem_type == MAD_NORMAL && m == MAD_DEM_WTH && e.inner == MAD_WBA)
      e.inner = MAD_WTH;
    if (e.mem_type == MAD_NORMAL && m == MAD_DEM_WTH && e.outer == MAD_WBA)
      e.outer = MAD_WTH;
    if (e.mem_type == MAD_NORMAL && m[1])
      e = '{MAD_NORMAL, MAD_NONCACHE, MAD_NONCACHE, e.shareable};
    return e;
  endfunction : dem

  // one request, expected result from the current control word
  task automatic access(input logic [31:0] ad, input logic f, input logic p,
                        input logic h, input logic [4:0] c, input logic s,
                        input logic x);
    mad_attr_t e;
    logic      dflt;
    logic      miss;
    logic      nox;
    logic      flt;
    dflt = !ctrl[0] || !h;
    miss = ctrl[0] && !h && !(p && ctrl[1]);
    e    = dflt ? exp_def(ad) : dem(exp_reg(c, s), ctrl[5:4]);
    nox  = dflt ? (ad[31:29] inside {3'h2, 3'h5, 3'h6, 3'h7})
                : (x || ad[31:29] == 3'h7);
    flt  = miss || (f && nox);
    if (flt)
      nflt++;
    i_core.send('{1'b1, ad, f, p, h, c, s, x});
    chk_bit(attr_valid, 1'b1);
    if (!miss)
      chk_attr(attr, e);
    chk_bit(execute_never, nox);
    chk_bit(memory_management_fault, flt && ctrl[2]);
    chk_bit(escalated_hard_fault, flt && !ctrl[2]);
    @(posedge ref_clk);
    #1;
    chk_bit(attr_valid | memory_management_fault | escalated_hard_fault,
            1'b0);
  endtask : access

  initial
  begin
    #500000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    compares = 0;
    nflt = 0;
    seed = 18004;
    ctrl = 32'h0000_0000;
    corner = '{32'he0000000, 32'he00ffffc, 32'he0100000, 32'hf0000000,
               32'h9ffffffc, 32'hdffffffc};
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_bit(attr_valid | memory_management_fault | escalated_hard_fault,
            1'b0);
    apb(1'b0, MAD_CTRL_OFF, 32'h0);
    chk_word(rd, MAD_CTRL_RESET);
    apb(1'b0, 12'h010, 32'h0);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0000_0000);
    for (int i = 0; i < 40; i++)
    begin
      a = {i[2:0], 29'($random(seed)) & 29'h1ffffffc};
      access(a, i[3], i[4], 1'($random(seed)), 5'h00, 1'b0, 1'b0);
    end
    foreach (corner[k])
    begin
      access(corner[k], 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
      access(corner[k], 1'b1, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
    end
    ctrl = 32'h0000_0004;
    apb(1'b1, MAD_CTRL_OFF, ctrl);
    access(32'h40000000, 1'b1, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
    apb(1'b0, MAD_STAT_OFF, 32'h0);
    chk_bit(rd[MAD_STAT_MM], 1'b1);
    chk_attr(mad_attr_t'(rd[6:0]), exp_def(32'h40000000));
    chk_bit(rd[MAD_STAT_DEF], 1'b1);
    apb(1'b0, MAD_FADDR_OFF, 32'h0);
    chk_word(rd, 32'h40000000);
    apb(1'b0, MAD_FCNT_OFF, 32'h0);
    chk_word(rd, nflt);
    apb(1'b1, MAD_FCNT_OFF, 32'h0);
    apb(1'b0, MAD_FCNT_OFF, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b1, MAD_STAT_OFF, 32'h0000_0100);
    apb(1'b0, MAD_STAT_OFF, 32'h0);
    chk_bit(rd[MAD_STAT_MM], 1'b0);
    ctrl = 32'h0000_0005;
    apb(1'b1, MAD_CTRL_OFF, ctrl);
    for (int c = 0; c < 64; c++)
    begin
      a = {3'h0, 29'($random(seed)) & 29'h1ffffffc};
      access(a, c[5], 1'b1, 1'b1, c[4:0], 1'($random(seed)), 1'b0);
    end
    access(32'he0001000, 1'b1, 1'b1, 1'b1, 5'h07, 1'b0, 1'b0);
    access(32'h20000000, 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
    ctrl = 32'h0000_0007;
    apb(1'b1, MAD_CTRL_OFF, ctrl);
    access(32'h20000000, 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
    access(32'ha0000000, 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
    access(32'h20000000, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
    for (int m = 1; m < 4; m++)
    begin
      ctrl = 32'h0000_0005 | (m << 4);
      apb(1'b1, MAD_CTRL_OFF, ctrl);
      access(32'h20000000, 1'b0, 1'b1, 1'b1, 5'h07, 1'b1, 1'b0);
      access(32'h20000000, 1'b0, 1'b1, 1'b1, 5'h15, 1'b0, 1'b0);
      access(32'h00000000, 1'b0, 1'b1, 1'b1, 5'h02, 1'b1, 1'b0);
    end
    end_sim();
  end
endmodule : test_memory_attribute_decode
